// file: include/slpol_pkg.sv
// Package for the serial load power output latch
package slpol_pkg;

  localparam int unsigned SLPOL_WIDTH = 8;
  localparam logic [7:0]  SLPOL_SHIFT_RST = 8'h00;
  localparam logic [7:0]  SLPOL_LATCH_RST = 8'h00;
  localparam logic [7:0]  SLPOL_CLEAR_VAL = 8'h00;
  localparam logic [7:0]  SLPOL_OFF_VAL   = 8'h00;
  localparam logic [1:0]  SLPOL_SYNC_RST  = 2'h0;
  localparam logic [1:0]  SLPOL_SYNC_RST1 = 2'h3;

  // Synchronised pin levels plus previous clock levels for edge detection
  typedef struct packed {
    logic [1:0] shift_clk_sync;
    logic [1:0] xfer_clk_sync;
    logic [1:0] data_sync;
    logic [1:0] clear_n_sync;
    logic [1:0] gate_n_sync;
    logic       shift_clk_prev;
    logic       xfer_clk_prev;
  } slpol_pins_s;

  typedef struct packed {
    logic [7:0] shift_r;
    logic [7:0] latch_r;
    logic [7:0] sink_on_r;
    logic       cascade_r;
  } slpol_core_s;

endpackage

// file: rtl/slpol_pin_sync.sv
// Two-stage synchronisers and edge detect for the serial pins
`timescale 1ns/1ps
`default_nettype none
module slpol_pin_sync
  import slpol_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Raw pins
  input  wire logic shift_stage_clock,
  input  wire logic latch_transfer_clock,
  input  wire logic serial_bit_in,
  input  wire logic shift_stage_clear_n,
  input  wire logic output_gate_n,
  // Synchronised levels and edges
  output logic      shift_rise,
  output logic      xfer_rise,
  output logic      data_s,
  output logic      clear_n_s,
  output logic      gate_n_s
);

  slpol_pins_s st_r;
  slpol_pins_s st_nxt;

  always_comb
  begin
    st_nxt                = st_r;
    st_nxt.shift_clk_sync = {st_r.shift_clk_sync[0], shift_stage_clock};
    st_nxt.xfer_clk_sync  = {st_r.xfer_clk_sync[0], latch_transfer_clock};
    st_nxt.data_sync      = {st_r.data_sync[0], serial_bit_in};
    st_nxt.clear_n_sync   = {st_r.clear_n_sync[0], shift_stage_clear_n};
    st_nxt.gate_n_sync    = {st_r.gate_n_sync[0], output_gate_n};
    st_nxt.shift_clk_prev = st_r.shift_clk_sync[1];
    st_nxt.xfer_clk_prev  = st_r.xfer_clk_sync[1];
  end

  // Gate resets high so the sinks start off
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r                <= '0;
      st_r.gate_n_sync    <= SLPOL_SYNC_RST1;
      st_r.clear_n_sync   <= SLPOL_SYNC_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Only the second stage is read, never the first
  assign shift_rise = st_r.shift_clk_sync[1] & ~st_r.shift_clk_prev;
  assign xfer_rise  = st_r.xfer_clk_sync[1] & ~st_r.xfer_clk_prev;
  assign data_s     = st_r.data_sync[1];
  assign clear_n_s  = st_r.clear_n_sync[1];
  assign gate_n_s   = st_r.gate_n_sync[1];

endmodule
`default_nettype wire

// file: rtl/slpol_top.sv
// Serial load power output latch, device side
`timescale 1ns/1ps
`default_nettype none
module slpol_top
  import slpol_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Serial and control pins
  input  wire logic       shift_stage_clock,
  input  wire logic       latch_transfer_clock,
  input  wire logic       serial_bit_in,
  input  wire logic       shift_stage_clear_n,
  input  wire logic       output_gate_n,
  // Outputs
  output logic      [7:0] sink_on,
  output logic            cascade_serial_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Every pin is sampled twice before any logic reads it
  ////////////////////////////////////////////////////////////////////////////
  logic shift_rise;
  logic xfer_rise;
  logic data_s;
  logic clear_n_s;
  logic gate_n_s;

  slpol_pin_sync u_sync (
    .sys_clk              (sys_clk),
    .rst_n                (rst_n),
    .shift_stage_clock    (shift_stage_clock),
    .latch_transfer_clock (latch_transfer_clock),
    .serial_bit_in        (serial_bit_in),
    .shift_stage_clear_n  (shift_stage_clear_n),
    .output_gate_n        (output_gate_n),
    .shift_rise           (shift_rise),
    .xfer_rise            (xfer_rise),
    .data_s               (data_s),
    .clear_n_s            (clear_n_s),
    .gate_n_s             (gate_n_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State and per-bit next values
  ////////////////////////////////////////////////////////////////////////////
  slpol_core_s st_r;
  slpol_core_s st_nxt;

  // Next value of each slice, gathered into the state below
  logic  [7:0] stage_nxt;
  logic  [7:0] latch_nxt;
  logic  [7:0] buffer_nxt;

  // Gate control shared by all slices, plus the cascade next value
  logic        buffer_open;
  logic        cascade_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Output gating
  ////////////////////////////////////////////////////////////////////////////
  // Pins pass two flops, so sinks answer three clocks after a pin change
  // Clear low also shuts the sinks, so a half-cleared chain never drives loads
  always_comb
  begin
    if (gate_n_s)
    begin
      buffer_open = 1'b0;
    end
    else if (!clear_n_s)
    begin
      buffer_open = 1'b0;
    end
    else
    begin
      buffer_open = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift stage, latch and buffer, one slice per output
  ////////////////////////////////////////////////////////////////////////////
  for (genvar gi = 0; gi < SLPOL_WIDTH; gi++)
  begin : g_bit
    logic from_below;
    logic stage_bit;
    logic latch_bit;
    logic buffer_bit;

    // Only slice zero reads the pin; the others take their lower neighbour
    if (gi == 0)
    begin : g_head
      assign from_below = data_s;
    end
    else
    begin : g_body
      assign from_below = st_r.shift_r[gi-1];
    end

    // Clear wins over a coincident shift edge
    always_comb
    begin
      if (!clear_n_s)
      begin
        stage_bit = SLPOL_CLEAR_VAL[gi];
      end
      else if (shift_rise)
      begin
        stage_bit = from_below;
      end
      else
      begin
        stage_bit = st_r.shift_r[gi];
      end
    end

    // Latch takes the stage as it stood before this edge, so a shift
    // and transfer arriving together behave like two chips in a chain
    always_comb
    begin
      if (xfer_rise)
      begin
        latch_bit = st_r.shift_r[gi];
      end
      else
      begin
        latch_bit = st_r.latch_r[gi];
      end
    end

    // Buffer follows the latch with no clock of its own
    always_comb
    begin
      if (buffer_open)
      begin
        buffer_bit = latch_bit;
      end
      else
      begin
        buffer_bit = SLPOL_OFF_VAL[gi];
      end
    end

    // High buffer bit means the sink conducts
    assign stage_nxt[gi]  = stage_bit;
    assign latch_nxt[gi]  = latch_bit;
    assign buffer_nxt[gi] = buffer_bit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cascade output
  ////////////////////////////////////////////////////////////////////////////
  // Kept beside the stage so the port comes straight from its own flop
  // Tracks the last stage, so a clear also zeroes it
  always_comb
  begin
    if (!clear_n_s)
    begin
      cascade_nxt = SLPOL_CLEAR_VAL[SLPOL_WIDTH-1];
    end
    else if (shift_rise)
    begin
      cascade_nxt = st_r.shift_r[SLPOL_WIDTH-2];
    end
    else
    begin
      cascade_nxt = st_r.cascade_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  ////////////////////////////////////////////////////////////////////////////
  // Hold cases live in the slices and the cascade logic, so this only gathers the fields
  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.shift_r   = stage_nxt;
    st_nxt.latch_r   = latch_nxt;
    st_nxt.sink_on_r = buffer_nxt;
    st_nxt.cascade_r = cascade_nxt;
  end

  // Reset leaves every sink off and the cascade low
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r.shift_r   <= SLPOL_SHIFT_RST;
      st_r.latch_r   <= SLPOL_LATCH_RST;
      st_r.sink_on_r <= SLPOL_OFF_VAL;
      st_r.cascade_r <= SLPOL_SHIFT_RST[SLPOL_WIDTH-1];
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flop
  // Sinks and cascade change only on the system clock
  ////////////////////////////////////////////////////////////////////////////
  assign sink_on            = st_r.sink_on_r;
  assign cascade_serial_out = st_r.cascade_r;

endmodule
`default_nettype wire

// file: dv/slpol_checker.sv
// Assertions on the latch ports
`timescale 1ns/1ps
`default_nettype none
module slpol_checker (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Pins
  input wire logic       shift_stage_clock,
  input wire logic       latch_transfer_clock,
  input wire logic       shift_stage_clear_n,
  input wire logic       output_gate_n,
  // Outputs
  input wire logic [7:0] sink_on,
  input wire logic       cascade_serial_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_clr; (!shift_stage_clear_n)[*4] |-> !cascade_serial_out; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_clr_off; (!shift_stage_clear_n)[*4] |-> sink_on == 8'h00; endproperty
  a_clr_off: assert property (p_clr_off) else $error("clr off");
  property p_gate; output_gate_n[*4] |-> sink_on == 8'h00; endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_gate_fast; $rose(output_gate_n) |-> ##3 sink_on == 8'h00; endproperty
  a_gate_fast: assert property (p_gate_fast) else $error("gate late");
  property p_on; sink_on != 8'h00 |-> !$past(output_gate_n, 3) && $past(shift_stage_clear_n, 3); endproperty
  a_on: assert property (p_on) else $error("on");
  // Sinks move only three cycles after a cause, never on a shift
  property p_cause; $changed(sink_on) |-> $past(latch_transfer_clock, 3) && !$past(latch_transfer_clock, 4)
    || $past(output_gate_n, 3) != $past(output_gate_n, 4)
    || $past(shift_stage_clear_n, 3) != $past(shift_stage_clear_n, 4); endproperty
  a_cause: assert property (p_cause) else $error("cause");
  property p_casc; $changed(cascade_serial_out) |-> $past(shift_stage_clock, 3) && !$past(shift_stage_clock, 4)
    || !$past(shift_stage_clear_n, 3); endproperty
  a_casc: assert property (p_casc) else $error("casc");
  property p_clr_fast; $fell(shift_stage_clear_n) |-> ##3 !cascade_serial_out; endproperty
  a_clr_fast: assert property (p_clr_fast) else $error("clr late");
endmodule
bind slpol_top slpol_checker chk (.*);
`default_nettype wire

// file: dv/slpol_ctrl_model.sv
// Controller model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module slpol_ctrl_model (
  input  wire logic sys_clk,
  output var logic  sck,
  output var logic  xck,
  output var logic  sdi
);
  int hw = 3;
  initial
  begin
    sck = 0;
    xck = 0;
    sdi = 0;
  end
  // Whole word shifted before transfer, so sinks change in one step
  task automatic send(logic [7:0] w, bit xfer);
    for (int i = 7; i >= 0; i--)
    begin
      sdi <= w[i];
      repeat (hw) @(posedge sys_clk);
      sck <= 1;
      repeat (hw) @(posedge sys_clk);
      sck <= 0;
    end
    xck <= xfer;
    repeat (hw) @(posedge sys_clk);
    xck <= 0;
    repeat (hw) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// file: dv/serial_load_power_output_latch_test.sv
// Testbench for the serial load power output latch
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    tests_run++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("wrong value %0t %h %h", $time, a, b); \
    end \
  end
module serial_load_power_output_latch_test;
  logic       sys_clk, rst_n, sck, xck, sdi, clr_n, gate_n, casc;
  logic [7:0] sink;
  int         miscompares, tests_run;
  slpol_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .shift_stage_clock(sck), .latch_transfer_clock(xck),
    .serial_bit_in(sdi), .shift_stage_clear_n(clr_n), .output_gate_n(gate_n), .sink_on(sink),
    .cascade_serial_out(casc));
  slpol_ctrl_model ctl (.sys_clk(sys_clk), .sck(sck), .xck(xck), .sdi(sdi));
  initial
  begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic w4;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic test_done;
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_load;
    ctl.send(8'ha5, 1);
    `CHK(sink, 8'ha5)
    `CHK(casc, 1'b1)
    ctl.send(8'h3c, 0);
    `CHK(sink, 8'ha5)
    `CHK(casc, 1'b0)
  endtask
  task automatic t_gate;
    ctl.hw = 6;
    gate_n <= 1;
    ctl.send(8'h81, 1);
    `CHK(sink, 8'h00)
    `CHK(casc, 1'b1)
    gate_n <= 0;
    w4;
    `CHK(sink, 8'h81)
  endtask
  // Shifts during clear are lost, so the transfer copies zeros
  task automatic t_clear;
    clr_n <= 0;
    w4;
    `CHK(sink, 8'h00)
    ctl.send(8'hff, 1);
    clr_n <= 1;
    w4;
    `CHK(sink, 8'h00)
    `CHK(casc, 1'b0)
  endtask
  initial
  begin
    rst_n = 0;
    clr_n = 1;
    gate_n = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1;
    w4;
    t_load;
    t_gate;
    t_clear;
    test_done;
  end
endmodule
`default_nettype wire
